// ===== sram_cycle_pkg.sv
// Constants and types shared by the burst SRAM cycle decode.
// Assumes a single 100 MHz core clock domain.
package sram_cycle_pkg;
  localparam int unsigned ADDR_W       = 18;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned LANES        = 4;
  localparam int unsigned LANE_W       = 8;
  localparam int unsigned DEPTH        = 262144;
  localparam int unsigned BURST_W      = 2;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Sleep entry time is two clock periods at most
  localparam int unsigned SLEEP_ENTRY_PERIODS = 2;
  localparam int unsigned SLEEP_ENTRY_NS =
    SLEEP_ENTRY_PERIODS * CLK_PERIOD_NS;
  localparam int unsigned SLEEP_ENTRY_CYC =
    (SLEEP_ENTRY_NS / CLK_PERIOD_NS < 1) ? 1
                                         : SLEEP_ENTRY_NS / CLK_PERIOD_NS;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [LANES-1:0]   LANES_ALL = 4'hF;
  localparam logic [LANES-1:0]   LANES_NONE = 4'h0;

  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_DESELECT,
    CYC_READ,
    CYC_WRITE,
    CYC_PROC_START
  } cycle_e;
endpackage

// ===== sram_core_mem.sv
// Word memory with per-lane write enables and a registered read port.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/1ps
module sram_core_mem
  import sram_cycle_pkg::*;
(
  // Clock
  input  wire logic                          core_clk,
  // Access
  input  wire logic [sram_cycle_pkg::ADDR_W-1:0] addr,
  input  wire logic [sram_cycle_pkg::LANES-1:0]  lane_we,
  input  wire logic [sram_cycle_pkg::DATA_W-1:0] wdata,
  input  wire logic [sram_cycle_pkg::LANES-1:0]  wpar,
  output logic      [sram_cycle_pkg::DATA_W-1:0] rdata,
  output logic      [sram_cycle_pkg::LANES-1:0]  rpar
);
  logic [LANE_W:0] mem [LANES][DEPTH];

  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    always_ff @(posedge core_clk)
    begin
      if (lane_we[g])
        mem[g][addr] <= {wpar[g], wdata[g*LANE_W +: LANE_W]};
      {rpar[g], rdata[g*LANE_W +: LANE_W]} <= mem[g][addr];
    end
  end
endmodule

// ===== sync_burst_sram_cycle_decode.sv
// Cycle decode and data-pin control of a pipelined burst SRAM.
// Assumes all pins are already synchronous to core_clk except out_enable_n
// and sleep_request, which are asynchronous by nature.
// Behaviour
// - Processor strobe with selects starts read unless asleep
// - Writes never happen in processor-strobe cycle
// - Controller strobe, selected, no write: read
// - Controller strobe, selected, write: burst write
// - No strobe, advance low, read: next
// - No strobe, advance low, write: next
// - No strobe, advance high: reread current
// - No strobe, advance high: rewrite current
// - Combined write from global or lane enables
// - Pin direction from cycle and output enable
// - Output enable acts asynchronously, never sampled
// - Drivers forced off only while cycle is CYC_WRITE, not in the cycle that starts a write
// - Read: float when enable high or deselected
// - Read with enable low drives word
// - Sleep reached within two clocks, pins floated
// - Deselect releases outputs one edge later
// - Two-bit wrapping counter, interleaved or linear
`timescale 1ns/1ps
module sync_burst_sram_cycle_decode
  import sram_cycle_pkg::*;
(
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              srst,
  // Selects and strobes
  input  wire logic                              chip_sel_primary_n,
  input  wire logic                              chip_sel_expand_hi,
  input  wire logic                              chip_sel_expand_lo_n,
  input  wire logic                              proc_addr_strobe_n,
  input  wire logic                              ctrl_addr_strobe_n,
  input  wire logic                              burst_advance_n,
  input  wire logic                              linear_burst,
  input  wire logic [sram_cycle_pkg::ADDR_W-1:0] addr,
  // Write controls
  input  wire logic                              global_write_n,
  input  wire logic                              byte_write_enable_n,
  input  wire logic [sram_cycle_pkg::LANES-1:0]  byte_lane_select_n,
  // Asynchronous controls
  input  wire logic                              out_enable_n,
  input  wire logic                              sleep_request,
  // Data pins, split into in, out and enable (enable low drives)
  input  wire logic [sram_cycle_pkg::DATA_W-1:0] data_in,
  output logic      [sram_cycle_pkg::DATA_W-1:0] data_out,
  output logic                                   data_oe_n,
  input  wire logic [sram_cycle_pkg::LANES-1:0]  parity_lines_in,
  output logic      [sram_cycle_pkg::LANES-1:0]  parity_lines_out,
  output logic                                   parity_oe_n,
  // Status
  output logic                                   asleep
);
  import sram_cycle_pkg::*;

  function automatic logic [BURST_W-1:0] burst_next(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] cnt,
    input logic               lin
  );
    logic [BURST_W-1:0] step;
    step = cnt + BURST_ONE;
    burst_next = lin ? start + step : start ^ step;
  endfunction

  logic                sleep_meta;
  logic                sleep_sync;
  logic [ADDR_W-1:0]   base_addr;
  logic [BURST_W-1:0]  burst_cnt;
  logic [BURST_W-1:0]  next_cnt;
  cycle_e              cycle;
  cycle_e              next_cycle;
  logic [ADDR_W-1:0]   access_addr;
  logic [LANES-1:0]    lane_we;
  logic                write_any;
  logic                strobe_hit;
  logic                selected;
  logic                read_valid;
  logic                drive_hold;
  logic [DATA_W-1:0]   rdata;
  logic [LANES-1:0]    rpar;

  // Sleep is a pin level from outside, so it is synchronised first
  always_ff @(posedge core_clk)
  begin
    sleep_meta <= sleep_request;
    sleep_sync <= sleep_meta;
  end

  always_comb
  begin
    write_any = !global_write_n ||
                (!byte_write_enable_n && (byte_lane_select_n != LANES_ALL));
    // Processor strobe is ignored while the primary select is high
    strobe_hit = (!proc_addr_strobe_n && !chip_sel_primary_n) ||
                 !ctrl_addr_strobe_n;
    selected = !chip_sel_primary_n && chip_sel_expand_hi &&
               !chip_sel_expand_lo_n;
  end

  always_comb
  begin
    next_cycle = cycle;
    next_cnt   = burst_cnt;
    if (sleep_sync)
      next_cycle = CYC_IDLE;
    else if (strobe_hit && !selected)
      next_cycle = CYC_DESELECT;
    else if (strobe_hit && !proc_addr_strobe_n)
    begin
      next_cycle = CYC_PROC_START;
      next_cnt   = '0;
    end
    else if (strobe_hit)
    begin
      next_cycle = write_any ? CYC_WRITE : CYC_READ;
      next_cnt   = '0;
    end
    else if (cycle != CYC_IDLE && cycle != CYC_DESELECT)
    begin
      next_cycle = write_any ? CYC_WRITE : CYC_READ;
      if (!burst_advance_n)
        next_cnt = burst_cnt + BURST_ONE;
      // Advance high keeps the counter
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      cycle <= CYC_IDLE;
    else
      cycle <= next_cycle;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      burst_cnt <= '0;
    else
      burst_cnt <= next_cnt;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      base_addr <= '0;
    else if (!sleep_sync && strobe_hit && selected)
      base_addr <= addr;
  end

  // Address of the access decided on this edge
  always_comb
  begin
    if (strobe_hit && selected)
      access_addr = addr;
    else
      access_addr = {base_addr[ADDR_W-1:BURST_W],
                     (next_cnt == '0) ? base_addr[BURST_W-1:0]
                     : burst_next(base_addr[BURST_W-1:0],
                                  next_cnt - BURST_ONE, linear_burst)};
  end

  // Writes only in controller-strobe or continuation cycles
  always_comb
  begin
    lane_we = LANES_NONE;
    if (next_cycle == CYC_WRITE)
      lane_we = !global_write_n ? LANES_ALL : ~byte_lane_select_n;
  end

  sram_core_mem u_mem (
    .core_clk (core_clk),
    .addr     (access_addr),
    .lane_we  (lane_we),
    .wdata    (data_in),
    .wpar     (parity_lines_in),
    .rdata    (rdata),
    .rpar     (rpar)
  );

  // Output register stage: a read word is valid one edge after decode
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      data_out         <= '0;
      parity_lines_out <= '0;
    end
    else
    begin
      data_out         <= rdata;
      parity_lines_out <= rpar;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      read_valid <= 1'b0;
    else
      read_valid <= !sleep_sync &&
                    (cycle == CYC_READ || cycle == CYC_PROC_START);
  end

  // Pipelined enable: drivers stay on until the edge after a deselect,
  // then float, so a bank switch never sees two drivers at once
  always_ff @(posedge core_clk)
  begin
    if (srst)
      drive_hold <= 1'b0;
    else
      drive_hold <= (cycle == CYC_READ || cycle == CYC_PROC_START) &&
                    next_cycle == CYC_DESELECT;
  end

  assign asleep = sleep_sync;

  // Output enable is combinational here, never registered
  always_comb
  begin
    data_oe_n = 1'b1;
    if (!sleep_sync && cycle != CYC_WRITE &&
        (read_valid || drive_hold) && !out_enable_n)
      data_oe_n = 1'b0;
    parity_oe_n = data_oe_n;
  end

  a_write_float: assert property (@(posedge core_clk) disable iff (srst)
    cycle == CYC_WRITE |-> data_oe_n)
    else $error("drivers on during write");
  a_sleep_entry: assert property (@(posedge core_clk) disable iff (srst)
    $rose(sleep_request) |-> ##[1:2] data_oe_n)
    else $error("sleep did not float pins");
  a_proc_read: assert property (@(posedge core_clk) disable iff (srst)
    !proc_addr_strobe_n && selected && !sleep_sync
    |=> cycle == CYC_PROC_START)
    else $error("processor strobe did not start read");
  a_proc_nowrite: assert property (@(posedge core_clk) disable iff (srst)
    !proc_addr_strobe_n && !chip_sel_primary_n |-> lane_we == LANES_NONE)
    else $error("write in processor strobe cycle");
  a_ctrl_write: assert property (@(posedge core_clk) disable iff (srst)
    !ctrl_addr_strobe_n && proc_addr_strobe_n && selected && write_any
    && !sleep_sync |=> cycle == CYC_WRITE)
    else $error("controller write not started");
  a_ctrl_read: assert property (@(posedge core_clk) disable iff (srst)
    !ctrl_addr_strobe_n && proc_addr_strobe_n && selected && !write_any
    && !sleep_sync |=> cycle == CYC_READ)
    else $error("controller read not started");
  sequence s_deselect_float;
    cycle == CYC_DESELECT ##1 data_oe_n;
  endsequence
  a_deselect: assert property (@(posedge core_clk) disable iff (srst)
    strobe_hit && !selected && !sleep_sync |=> s_deselect_float)
    else $error("deselect not decoded or pins not released");
  a_suspend_hold: assert property (@(posedge core_clk) disable iff (srst)
    !strobe_hit && burst_advance_n && !sleep_sync |=> $stable(burst_cnt))
    else $error("counter moved on suspend");
  a_advance_step: assert property (@(posedge core_clk) disable iff (srst)
    !strobe_hit && !burst_advance_n && !sleep_sync
    && (cycle == CYC_READ || cycle == CYC_WRITE)
    |=> burst_cnt == $past(burst_cnt) + BURST_ONE)
    else $error("counter did not advance");
endmodule

// ===== host_model.sv
// Host bus master that drives the cycle decode's pins from bench calls.
// Assumes the bench calls one task at a time, 1 ns after a clock edge.
`timescale 1ns/1ps
module host_model
  import sram_cycle_pkg::*;
(
  // Clock
  input  wire logic                              core_clk,
  // Selects, strobes and address
  output logic                                   chip_sel_primary_n,
  output logic                                   chip_sel_expand_hi,
  output logic                                   chip_sel_expand_lo_n,
  output logic                                   proc_addr_strobe_n,
  output logic                                   ctrl_addr_strobe_n,
  output logic                                   burst_advance_n,
  output logic                                   linear_burst,
  output logic      [sram_cycle_pkg::ADDR_W-1:0] addr,
  // Write controls
  output logic                                   global_write_n,
  output logic                                   byte_write_enable_n,
  output logic      [sram_cycle_pkg::LANES-1:0]  byte_lane_select_n,
  // Asynchronous controls
  output logic                                   out_enable_n,
  output logic                                   sleep_request,
  // Write data
  output logic      [sram_cycle_pkg::DATA_W-1:0] data_in,
  output logic      [sram_cycle_pkg::LANES-1:0]  parity_lines_in
);
  initial
  begin
    chip_sel_expand_hi = 1'b1;
    chip_sel_expand_lo_n = 1'b0;
    out_enable_n = 1'b1;
    sleep_request = 1'b0;
    linear_burst = 1'b1;
    data_in = '0;
    parity_lines_in = '0;
    cyc_set(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, LANES_ALL, '0);
  end

  task automatic cyc_set(input logic sel_n, ps_n, cs_n, adv_n, gw_n, bwe_n,
                         input logic [LANES-1:0] bl_n,
                         input logic [ADDR_W-1:0] a);
    chip_sel_primary_n = sel_n;
    proc_addr_strobe_n = ps_n;
    ctrl_addr_strobe_n = cs_n;
    burst_advance_n = adv_n;
    global_write_n = gw_n;
    byte_write_enable_n = bwe_n;
    byte_lane_select_n = bl_n;
    addr = a;
  endtask

  // One bus cycle; released data lines toggle so stale words never match
  task automatic cyc(input logic sel_n, ps_n, cs_n, adv_n, gw_n, bwe_n,
                     input logic [LANES-1:0] bl_n,
                     input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    logic wr;
    wr = !gw_n || (!bwe_n && bl_n != LANES_ALL);
    if (wr && ps_n && !cs_n)
      out_enable_n = 1'b1;
    cyc_set(sel_n, ps_n, cs_n, adv_n, gw_n, bwe_n, bl_n, a);
    data_in = wr ? d : ~data_in;
    parity_lines_in = wr ? d[31:28] : ~parity_lines_in;
    @(posedge core_clk);
    #1;
  endtask

  task automatic wake();
    sleep_request = 1'b0;
    cyc_set(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, LANES_ALL, '0);
    repeat (3) @(posedge core_clk);
    #1;
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the burst SRAM cycle decode.
// Assumes host_model drives every device input except core_clk and srst, which the bench drives.
`timescale 1ns/1ps
module tb;
  import sram_cycle_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 18'h00100;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic chip_sel_primary_n, chip_sel_expand_hi, chip_sel_expand_lo_n;
  logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
  logic linear_burst, global_write_n, byte_write_enable_n;
  logic out_enable_n, sleep_request, data_oe_n, parity_oe_n, asleep;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  byte_lane_select_n, parity_lines_in, parity_lines_out;
  logic [DATA_W-1:0] data_in, data_out;
  int fails = 0;
  int comparisons = 0;

  always #5 core_clk = ~core_clk;

  host_model u_host (.core_clk, .chip_sel_primary_n, .chip_sel_expand_hi,
    .chip_sel_expand_lo_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_advance_n, .linear_burst, .addr, .global_write_n,
    .byte_write_enable_n, .byte_lane_select_n, .out_enable_n,
    .sleep_request, .data_in, .parity_lines_in);

  sync_burst_sram_cycle_decode u_dut (.core_clk, .srst, .chip_sel_primary_n,
    .chip_sel_expand_hi, .chip_sel_expand_lo_n, .proc_addr_strobe_n,
    .ctrl_addr_strobe_n, .burst_advance_n, .linear_burst, .addr,
    .global_write_n, .byte_write_enable_n, .byte_lane_select_n,
    .out_enable_n, .sleep_request, .data_in, .data_out, .data_oe_n,
    .parity_lines_in, .parity_lines_out, .parity_oe_n, .asleep);

  function automatic logic [DATA_W-1:0] w(input int i);
    return 32'h5A5A0000 + 32'(i);
  endfunction

  task automatic chk_word(input logic [35:0] exp);
    comparisons++;
    if ({parity_lines_out, data_out} !== exp)
    begin
      fails++;
      $display("mismatch at %0t: word %h not %h", $time,
               {parity_lines_out, data_out}, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: flag %b not %b", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    u_host.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, a, '0);
  endtask

  task automatic cont(input logic adv_n, gw_n, input logic [DATA_W-1:0] d);
    u_host.cyc(1'b1, 1'b1, 1'b1, adv_n, gw_n, 1'b1, 4'hF, '0, d);
  endtask

  task automatic desel();
    u_host.cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, '0, '0);
  endtask

  task automatic t_write_burst();
    u_host.linear_burst = 1'b1;
    u_host.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, BASE + 18'h1,
               w(0));
    u_host.out_enable_n = 1'b0;
    for (int i = 1; i < 4; i++)
    begin
      chk_bit(data_oe_n, 1'b1);
      chk_bit(parity_oe_n, 1'b1);
      cont(1'b0, 1'b0, w(i));
    end
    $display("test write_burst done");
  endtask

  task automatic t_read_burst();
    int ord[5] = '{0, 3, 2, 1, 1};
    u_host.linear_burst = 1'b0;
    rd(BASE + 18'h1);
    for (int i = 1; i < 7; i++)
    begin
      cont(i > 3, 1'b1, '0);
      if (i <= 5)
      begin
        chk_word({4'h5, w(ord[i-1])});
        chk_bit(data_oe_n, 1'b0);
        chk_bit(parity_oe_n, 1'b0);
      end
    end
    u_host.out_enable_n = 1'b1;
    #1;
    chk_bit(data_oe_n, 1'b1);
    @(posedge core_clk);
    #1;
    u_host.out_enable_n = 1'b0;
    #1;
    chk_bit(data_oe_n, 1'b0);
    @(posedge core_clk);
    #1;
    desel();
    chk_bit(data_oe_n, 1'b0);
    desel();
    chk_bit(data_oe_n, 1'b1);
    $display("test read_burst done");
  endtask

  task automatic t_lane_proc();
    u_host.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hB, BASE,
               32'h11223344);
    u_host.out_enable_n = 1'b0;
    u_host.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, BASE,
               32'hFFFFFFFF);
    cont(1'b1, 1'b1, '0);
    cont(1'b1, 1'b1, '0);
    chk_word({4'h1, 32'h5A220003});
    desel();
    desel();
    $display("test lane_proc done");
  endtask

  task automatic t_sleep();
    u_host.sleep_request = 1'b1;
    rd(BASE);
    cont(1'b1, 1'b1, '0);
    chk_bit(asleep, 1'b1);
    chk_bit(data_oe_n, 1'b1);
    u_host.wake();
    rd(BASE);
    cont(1'b1, 1'b1, '0);
    cont(1'b1, 1'b1, '0);
    chk_word({4'h1, 32'h5A220003});
    $display("test sleep done");
  endtask

  // Processor strobe opens the access; the write lands on the next edge
  task automatic t_proc_write();
    u_host.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, BASE + 18'h2,
               '0);
    u_host.out_enable_n = 1'b1;
    cont(1'b1, 1'b0, 32'h0BADF00D);
    u_host.out_enable_n = 1'b0;
    rd(BASE + 18'h2);
    cont(1'b1, 1'b1, '0);
    chk_word({4'h0, 32'h0BADF00D});
    desel();
    desel();
    $display("test proc_write done");
  endtask

  task automatic finish_test();
    $display("counts: comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk);
    #1;
    srst = 1'b0;
    t_write_burst();
    t_read_burst();
    t_lane_proc();
    t_sleep();
    t_proc_write();
    finish_test();
  end
endmodule
